// ==== hw/rsfr_cfg.svh ====
`ifndef RSFR_CFG_SVH
`define RSFR_CFG_SVH
// register offsets on the plain register port
`define RSFR_A_REACT 8'h00
`define RSFR_A_OFFSET 8'h01
`define RSFR_A_CHECK 8'h02
`define RSFR_A_AUXSRC 8'h03
`define RSFR_A_FLAGS 8'h04
`define RSFR_A_STATUS 8'h05
// field positions inside the registers
`define RSFR_F_REACT 11:0
`define RSFR_F_MAX 13:12
`define RSFR_F_OFS 4:0
`define RSFR_F_SRC 2:0
`define RSFR_F_FLAGS 5:0
// reset values
`define RSFR_OV_RST 2'h2
`define RSFR_UV_RST 2'h1
`define RSFR_MAX_RST 2'h1
`define RSFR_OFS_RST 5'h00
`define RSFR_SRC_RST 3'h0
`define RSFR_TALLY_INIT 4'h1
// tally maximum per selection code
`define RSFR_MAX0 4'h2
`define RSFR_MAX1 4'h6
`define RSFR_MAX2 4'h8
`define RSFR_MAX3 4'hC
// rail indices
`define RSFR_CORE 0
`define RSFR_IO 1
`define RSFR_AUX 2
// regulator switch-off indices
`define RSFR_OFF_CORE 0
`define RSFR_OFF_PRE 1
`define RSFR_OFF_LDO 2
`define RSFR_OFF_BUCK3 3
// source select codes, anything else is external
`define RSFR_SRC_PRE 3'h1
`define RSFR_SRC_LDO 3'h2
`define RSFR_SRC_BUCK3 3'h3
// clock rate in MHz and deglitch times in microseconds
`define RSFR_CLK_MHZ 25
`define RSFR_OV_DGL0_US 25
`define RSFR_OV_DGL1_US 45
`define RSFR_UV_DGL0_US 5
`define RSFR_UV_DGL1_US 15
`define RSFR_UV_DGL2_US 25
`define RSFR_UV_DGL3_US 40
`define RSFR_CYC(us) (11'((us) * `RSFR_CLK_MHZ))
`endif

// ==== hw/rsfr_pkg.sv ====
package rsfr_pkg;
    // reaction fields of one rail
    typedef struct packed {
        logic [1:0] uv;
        logic [1:0] ov;
    } rsfr_react_t;
    // one-time settings of one rail
    typedef struct packed {
        logic [7:0] ov_thr;
        logic [7:0] uv_thr;
        logic ov_dgl_sel;
        logic [1:0] uv_dgl_sel;
        logic pg_on_ov;
        logic pg_on_uv;
    } rsfr_rail_otp_t;
    // whole one-time configuration
    typedef struct packed {
        rsfr_rail_otp_t [2:0] rail;
        logic pg_follows_reset_sel;
        logic [2:0] io_rail_source_sel;
        logic aux_mon_en;
    } rsfr_otp_t;
    // threshold codes handed to the comparators
    typedef struct packed {
        logic [7:0] ov;
        logic [7:0] uv;
    } rsfr_thr_t;
endpackage

// ==== hw/rsfr_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// three-stage synchroniser, state moves when stages two and three agree
module rsfr_sync (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] async_in,
    output logic [7:0] level_out
);
    logic [7:0] s1, s2, s3; // s1 only feeds s2
    logic [7:0] next_level;

    // agreement filter
    always_comb begin
        next_level = level_out;
        for (int i = 0; i < 8; i++) begin
            if (s2[i] == s3[i]) begin
                next_level[i] = s3[i];
            end
        end
    end

    // stage registers
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            s1 <= 8'h00;
            s2 <= 8'h00;
            s3 <= 8'h00;
            level_out <= 8'h00;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            level_out <= next_level;
        end
    end
endmodule
`default_nettype wire

// ==== hw/rsfr_deglitch.sv ====
`timescale 1ns/100ps
`default_nettype none
// a detection is accepted once it held for limit_in cycles
module rsfr_deglitch (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic level_in,
    input wire logic enable_in,
    input wire logic [10:0] limit_in,
    output logic accepted_out
);
    logic [10:0] cnt; // persistence counter
    logic [10:0] next_cnt;
    logic next_acc;

    // count persistence, drop at once when the fault goes away
    always_comb begin
        next_cnt = cnt;
        next_acc = accepted_out;
        if (!enable_in || !level_in) begin
            next_cnt = 11'h000;
            next_acc = 1'b0;
        end else if (!accepted_out) begin
            if (cnt == limit_in - 11'h001) begin
                next_acc = 1'b1;
            end else begin
                next_cnt = cnt + 11'h001;
            end
        end
    end

    // counter registers
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            cnt <= 11'h000;
            accepted_out <= 1'b0;
        end else begin
            cnt <= next_cnt;
            accepted_out <= next_acc;
        end
    end

    chk_dgl_hold_time: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        $rose(accepted_out) |-> $past(cnt) == limit_in - 11'h001)
        else $error("fault accepted before its deglitch time");
endmodule
`default_nettype wire

// ==== hw/rsfr_supervisor.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rsfr_cfg.svh"
module rsfr_supervisor (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic failsafe_init_phase_in,
    input wire logic safety_enable_in,
    input wire logic standby_resume_in,
    input wire logic [2:0] ov_sense_in,
    input wire logic [2:0] uv_sense_in,
    input wire rsfr_pkg::rsfr_otp_t otp_in,
    input wire logic reset_pin_in,
    output logic reset_out_n_out,
    output logic reset_oe_n_out,
    input wire logic power_good_pin_in,
    output logic power_good_out,
    output logic power_good_oe_n_out,
    output logic [3:0] reg_off_out,
    output logic [4:0] core_offset_out,
    output logic scaling_busy_out,
    output rsfr_pkg::rsfr_thr_t [2:0] thr_out,
    output logic deep_safe_state_out
);
    logic [7:0] pins; // synchronised comparator and pin levels
    logic [2:0] ov_ok, uv_ok; // accepted detections
    logic [2:0] ov_prev, uv_prev; // for new-fault edges
    logic [2:0] mon_en; // per-rail supervision enable
    logic [10:0] core_ov_cyc; // selected core overvoltage deglitch
    rsfr_pkg::rsfr_react_t [2:0] react, next_react;
    logic [1:0] max_sel, next_max_sel;
    logic [4:0] core_offset_code, next_offset_code; // pending offset
    logic [4:0] next_applied;
    logic [10:0] busy_cnt, next_busy_cnt;
    logic [2:0] aux_rail_source_reg, next_aux_src;
    logic [5:0] flags, next_flags; // {uv, ov} sticky flags
    logic [3:0] fault_tally, next_tally;
    logic next_deep;
    logic [3:0] tally_max;
    logic [2:0] rst_fault, pg_fault, new_rst;
    logic rst_assert, pg_assert;
    logic [3:0] next_off;
    logic [15:0] next_rdata;
    logic wr_init; // write allowed for init-only fields

    // pins from outside the clock domain
    rsfr_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .async_in({power_good_pin_in, reset_pin_in, uv_sense_in, ov_sense_in}),
        .level_out(pins)
    );

    // core ov deglitch also bounds the scaling transition
    assign core_ov_cyc = otp_in.rail[`RSFR_CORE].ov_dgl_sel ?
        `RSFR_CYC(`RSFR_OV_DGL1_US) : `RSFR_CYC(`RSFR_OV_DGL0_US);

    // one filter pair per rail
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_rail
            logic [10:0] ov_lim, uv_lim;
            always_comb begin
                ov_lim = otp_in.rail[g].ov_dgl_sel ?
                    `RSFR_CYC(`RSFR_OV_DGL1_US) : `RSFR_CYC(`RSFR_OV_DGL0_US);
                unique case (otp_in.rail[g].uv_dgl_sel)
                    2'h0: uv_lim = `RSFR_CYC(`RSFR_UV_DGL0_US);
                    2'h1: uv_lim = `RSFR_CYC(`RSFR_UV_DGL1_US);
                    2'h2: uv_lim = `RSFR_CYC(`RSFR_UV_DGL2_US);
                    2'h3: uv_lim = `RSFR_CYC(`RSFR_UV_DGL3_US);
                endcase
            end
            rsfr_deglitch u_ov (
                .sys_clk_in(sys_clk_in),
                .rst_b_in(rst_b_in),
                .level_in(pins[g]),
                .enable_in(mon_en[g]),
                .limit_in(ov_lim),
                .accepted_out(ov_ok[g])
            );
            rsfr_deglitch u_uv (
                .sys_clk_in(sys_clk_in),
                .rst_b_in(rst_b_in),
                .level_in(pins[g + 3]),
                .enable_in(mon_en[g]),
                .limit_in(uv_lim),
                .accepted_out(uv_ok[g])
            );
            // reset decision uses only the upper reaction bit
            assign rst_fault[g] = (ov_ok[g] & react[g].ov[1]) |
                (uv_ok[g] & react[g].uv[1]);
            assign new_rst[g] = (ov_ok[g] & ~ov_prev[g] & react[g].ov[1]) |
                (uv_ok[g] & ~uv_prev[g] & react[g].uv[1]);
            assign pg_fault[g] = (ov_ok[g] & otp_in.rail[g].pg_on_ov) |
                (uv_ok[g] & otp_in.rail[g].pg_on_uv) |
                (otp_in.pg_follows_reset_sel & rst_fault[g]);
        end
    endgenerate

    // supervision gating; core is masked while its rail moves
    always_comb begin
        mon_en = {3{safety_enable_in}};
        mon_en[`RSFR_AUX] = safety_enable_in & otp_in.aux_mon_en;
        mon_en[`RSFR_CORE] = safety_enable_in & (busy_cnt == 11'h000);
    end

    // pin hierarchy: pg drags reset with it, deep state holds both
    assign pg_assert = |pg_fault | deep_safe_state_out;
    assign rst_assert = |rst_fault | pg_assert;

    // configuration fields, init phase only except the aux source
    assign wr_init = reg_wr_in & failsafe_init_phase_in;
    always_comb begin
        next_react = react;
        next_max_sel = max_sel;
        next_offset_code = core_offset_code;
        next_aux_src = aux_rail_source_reg;
        if (wr_init && reg_addr_in == `RSFR_A_REACT) begin
            next_react = reg_wdata_in[`RSFR_F_REACT];
            next_max_sel = reg_wdata_in[`RSFR_F_MAX];
        end
        if (wr_init && reg_addr_in == `RSFR_A_OFFSET) begin
            next_offset_code = reg_wdata_in[`RSFR_F_OFS];
        end
        // source may be changed at any time
        if (reg_wr_in && reg_addr_in == `RSFR_A_AUXSRC) begin
            next_aux_src = reg_wdata_in[`RSFR_F_SRC];
        end
    end

    // configuration registers, defaults on power-on reset
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < 3; i++) begin
                react[i].ov <= `RSFR_OV_RST;
                react[i].uv <= `RSFR_UV_RST;
            end
            max_sel <= `RSFR_MAX_RST;
            core_offset_code <= `RSFR_OFS_RST;
            aux_rail_source_reg <= `RSFR_SRC_RST;
        end else begin
            react <= next_react;
            max_sel <= next_max_sel;
            core_offset_code <= next_offset_code;
            aux_rail_source_reg <= next_aux_src;
        end
    end

    // complement check; a mismatch leaves the rail where it was
    always_comb begin
        next_applied = core_offset_out;
        next_busy_cnt = busy_cnt;
        if (busy_cnt != 11'h000) begin
            next_busy_cnt = busy_cnt - 11'h001;
        end
        if (wr_init && reg_addr_in == `RSFR_A_CHECK &&
            reg_wdata_in[`RSFR_F_OFS] == ~core_offset_code) begin
            next_applied = core_offset_code;
            next_busy_cnt = core_ov_cyc;
        end
    end

    // scaling state
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            core_offset_out <= `RSFR_OFS_RST;
            busy_cnt <= 11'h000;
            scaling_busy_out <= 1'b0;
        end else begin
            core_offset_out <= next_applied;
            busy_cnt <= next_busy_cnt;
            scaling_busy_out <= next_busy_cnt != 11'h000;
        end
    end

    // sticky flags, a new detection beats a clear
    always_comb begin
        next_flags = flags;
        if (reg_wr_in && reg_addr_in == `RSFR_A_FLAGS) begin
            next_flags = flags & ~reg_wdata_in[`RSFR_F_FLAGS];
        end
        next_flags = next_flags | {uv_ok, ov_ok};
    end

    // tally maximum per selection
    always_comb begin
        unique case (max_sel)
            2'h0: tally_max = `RSFR_MAX0;
            2'h1: tally_max = `RSFR_MAX1;
            2'h2: tally_max = `RSFR_MAX2;
            2'h3: tally_max = `RSFR_MAX3;
        endcase
    end

    // fault tally; only counts while reset is released
    always_comb begin
        next_tally = fault_tally;
        next_deep = deep_safe_state_out | (fault_tally >= tally_max);
        if (standby_resume_in) begin
            next_tally = `RSFR_TALLY_INIT;
        end else if (reset_oe_n_out && fault_tally < tally_max) begin
            next_tally = fault_tally + 4'(new_rst[0]) + 4'(new_rst[1]) +
                4'(new_rst[2]);
        end
    end

    // tally, flags and edge history
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            fault_tally <= `RSFR_TALLY_INIT;
            deep_safe_state_out <= 1'b0;
            flags <= 6'h00;
            ov_prev <= 3'h0;
            uv_prev <= 3'h0;
        end else begin
            fault_tally <= next_tally;
            deep_safe_state_out <= next_deep;
            flags <= next_flags;
            ov_prev <= ov_ok;
            uv_prev <= uv_ok;
        end
    end

    // regulators stay off as long as the overvoltage stands
    always_comb begin
        next_off = 4'h0;
        next_off[`RSFR_OFF_CORE] = ov_ok[`RSFR_CORE];
        unique case (otp_in.io_rail_source_sel)
            `RSFR_SRC_PRE: next_off[`RSFR_OFF_PRE] = ov_ok[`RSFR_IO];
            `RSFR_SRC_LDO: next_off[`RSFR_OFF_LDO] = ov_ok[`RSFR_IO];
            `RSFR_SRC_BUCK3: next_off[`RSFR_OFF_BUCK3] = ov_ok[`RSFR_IO];
            default: ; // external feed, flag only
        endcase
        unique case (aux_rail_source_reg)
            `RSFR_SRC_PRE: next_off[`RSFR_OFF_PRE] |= ov_ok[`RSFR_AUX];
            `RSFR_SRC_LDO: next_off[`RSFR_OFF_LDO] |= ov_ok[`RSFR_AUX];
            `RSFR_SRC_BUCK3: next_off[`RSFR_OFF_BUCK3] |= ov_ok[`RSFR_AUX];
            default: ;
        endcase
    end

    // read mux, data stand for one cycle only
    always_comb begin
        next_rdata = 16'h0000;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `RSFR_A_REACT: next_rdata = {2'h0, max_sel, react};
                `RSFR_A_OFFSET: next_rdata = {11'h000, core_offset_code};
                `RSFR_A_AUXSRC: next_rdata = {13'h0000, aux_rail_source_reg};
                `RSFR_A_FLAGS: next_rdata = {10'h000, flags};
                `RSFR_A_STATUS: next_rdata = {3'h0, core_offset_out, pins[7:6],
                    scaling_busy_out, deep_safe_state_out, fault_tally};
                default: next_rdata = 16'h0000; // check and unmapped read zero
            endcase
        end
    end

    // pin and output registers; open-drain enables are active low
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            reset_out_n_out <= 1'b0;
            reset_oe_n_out <= 1'b0;
            power_good_out <= 1'b0;
            power_good_oe_n_out <= 1'b0;
            reg_off_out <= 4'h0;
            thr_out <= '0;
            reg_rdata_out <= 16'h0000;
        end else begin
            reset_out_n_out <= 1'b0;
            reset_oe_n_out <= ~rst_assert;
            power_good_out <= 1'b0;
            power_good_oe_n_out <= ~pg_assert;
            reg_off_out <= next_off;
            for (int i = 0; i < 3; i++) begin
                thr_out[i].ov <= otp_in.rail[i].ov_thr;
                thr_out[i].uv <= otp_in.rail[i].uv_thr;
            end
            reg_rdata_out <= next_rdata;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    chk_pg_over_reset: assert property (!power_good_oe_n_out |-> !reset_oe_n_out)
        else $error("power good asserted without reset");
    chk_react_defaults: assert property ($rose(rst_b_in) |->
        react[0].ov == `RSFR_OV_RST && react[2].uv == `RSFR_UV_RST)
        else $error("reaction field not at default after reset");
    chk_late_write_ignored: assert property (reg_wr_in && !failsafe_init_phase_in
        |=> $stable(react) && $stable(core_offset_code) && $stable(max_sel))
        else $error("init-only field changed outside init");
    chk_bad_complement: assert property (wr_init && reg_addr_in == `RSFR_A_CHECK &&
        reg_wdata_in[`RSFR_F_OFS] != ~core_offset_code && busy_cnt == 11'h000
        |=> $stable(core_offset_out) && !scaling_busy_out)
        else $error("scaling ran on a bad complement");
    chk_good_complement: assert property (wr_init && reg_addr_in == `RSFR_A_CHECK &&
        reg_wdata_in[`RSFR_F_OFS] == ~core_offset_code
        |=> core_offset_out == $past(core_offset_code) && scaling_busy_out)
        else $error("matching complement did not start scaling");
    chk_resume_tally: assert property (standby_resume_in |=> fault_tally == `RSFR_TALLY_INIT)
        else $error("tally not back at one after resume");
    chk_deep_entry: assert property (fault_tally >= tally_max |=> deep_safe_state_out)
        else $error("deep safe state missed at tally maximum");
    // every flag bit, so the io flags that the scenarios raise are watched too
    chk_flag_sticky: assert property (!(reg_wr_in &&
        reg_addr_in == `RSFR_A_FLAGS) |=> (flags & $past(flags)) == $past(flags))
        else $error("fault flag dropped without a clear");
    chk_enable_gate: assert property (!safety_enable_in |=> ov_ok == 3'h0 &&
        uv_ok == 3'h0)
        else $error("supervision active without safety enable");
    chk_io_off_ldo: assert property (ov_ok[`RSFR_IO] &&
        otp_in.io_rail_source_sel == `RSFR_SRC_LDO |=> reg_off_out[`RSFR_OFF_LDO])
        else $error("io rail regulator left on in overvoltage");
    chk_quiet_fault: assert property (reset_oe_n_out && new_rst == 3'h0 &&
        !standby_resume_in |=> $stable(fault_tally))
        else $error("tally moved without a reset fault");
    chk_reset_fault: assert property (|rst_fault |=> !reset_oe_n_out)
        else $error("reset not asserted for reset fault");

    cov_scaling: cover property (scaling_busy_out ##1 !scaling_busy_out);
    cov_deep: cover property ($rose(deep_safe_state_out));
    cov_pg_fault: cover property (!power_good_oe_n_out);
endmodule
`default_nettype wire

// ==== testbench/rsfr_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// host side of the reset and power-good wires, open drain with pull-ups
module rsfr_host_model (
    input wire logic reset_drive_in,
    input wire logic reset_oe_n_in,
    input wire logic pg_drive_in,
    input wire logic pg_oe_n_in,
    output logic reset_pin_out,
    output logic pg_pin_out
);
    // released wire floats to the pull-up level, never the last driven value
    assign reset_pin_out = reset_oe_n_in ? 1'b1 : reset_drive_in;
    assign pg_pin_out = pg_oe_n_in ? 1'b1 : pg_drive_in;
endmodule
`default_nettype wire

// ==== testbench/tb_rail_supervisor_fault_reaction.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rsfr_cfg.svh"
module tb_rail_supervisor_fault_reaction;
    logic clk, rst_b, wr, rd, init, en, stby, rpin, ppin, rdrv, roe_n, pdrv, poe_n, deep, busy;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, d;
    logic [2:0] ov, uv;
    logic [3:0] off;
    logic [4:0] ofs;
    rsfr_pkg::rsfr_otp_t otp;
    rsfr_pkg::rsfr_thr_t [2:0] thr;
    int error_cnt, comparisons, cyc, n;
    rsfr_supervisor uut (.sys_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .failsafe_init_phase_in(init), .safety_enable_in(en), .standby_resume_in(stby),
        .ov_sense_in(ov), .uv_sense_in(uv), .otp_in(otp), .reset_pin_in(rpin),
        .reset_out_n_out(rdrv), .reset_oe_n_out(roe_n), .power_good_pin_in(ppin),
        .power_good_out(pdrv), .power_good_oe_n_out(poe_n), .reg_off_out(off),
        .core_offset_out(ofs), .scaling_busy_out(busy), .thr_out(thr),
        .deep_safe_state_out(deep));
    rsfr_host_model host (.reset_drive_in(rdrv), .reset_oe_n_in(roe_n), .pg_drive_in(pdrv),
        .pg_oe_n_in(poe_n), .reset_pin_out(rpin), .pg_pin_out(ppin));
    // free-running clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard, a few thousand cycles of tests expected
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe edge
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // counts cycles until reset is pulled, bounded
    task automatic wait_rst(output int k);
        k = 0;
        while (roe_n !== 1'b0 && k < 800) begin
            @(posedge clk);
            #1 k++;
        end
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {rst_b, wr, rd, init, en, stby, ov, uv, addr, wdata} = '0;
        {error_cnt, comparisons} = '0;
        otp = '0;
        otp.pg_follows_reset_sel = 1'b1;
        otp.io_rail_source_sel = `RSFR_SRC_LDO;
        otp.aux_mon_en = 1'b1;
        otp.rail[0].ov_thr = 8'h0F;
        otp.rail[0].uv_thr = 8'hF0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        // reset values and map
        rd_reg(`RSFR_A_REACT, d); check(d, 16'h1666);
        rd_reg(`RSFR_A_OFFSET, d); check(d, 16'h0000);
        rd_reg(`RSFR_A_STATUS, d); check(d, 16'h00C1);
        rd_reg(8'h07, d); check(d, 16'h0000);
        check({thr[0].ov, thr[0].uv}, 16'h0FF0);
        // outside init the reaction fields hold
        wr_reg(`RSFR_A_REACT, 16'h0000);
        rd_reg(`RSFR_A_REACT, d); check(d, 16'h1666);
        @(posedge clk);
        init <= 1'b1;
        // scaling: wrong complement first, then the right one
        wr_reg(`RSFR_A_OFFSET, 16'h0004);
        wr_reg(`RSFR_A_CHECK, 16'h001A);
        repeat (2) @(posedge clk);
        check({11'h000, ofs}, 16'h0000);
        wr_reg(`RSFR_A_CHECK, 16'h001B);
        @(posedge clk);
        #1 check({11'h000, ofs}, 16'h0004);
        n = 0;
        while (busy === 1'b1 && n < 1200) begin
            @(posedge clk);
            #1 n++;
        end
        check(16'(n >= 620 && n <= 630), 16'h0001);
        // supervision off: no detection
        @(posedge clk);
        ov <= 3'h2;
        repeat (800) @(posedge clk);
        check({15'h0, roe_n}, 16'h0001);
        rd_reg(`RSFR_A_FLAGS, d); check(d, 16'h0000);
        @(posedge clk);
        ov <= 3'h0;
        en <= 1'b1;
        repeat (10) @(posedge clk);
        // io overvoltage with default reaction
        ov <= 3'h2;
        wait_rst(n);
        check(16'(n >= 626 && n <= 634), 16'h0001);
        check({12'h000, off}, 16'h0004);
        check({15'h0, poe_n}, 16'h0000);
        @(posedge clk);
        ov <= 3'h0;
        repeat (12) @(posedge clk);
        check({12'h000, off}, 16'h0000);
        check({15'h0, roe_n}, 16'h0001);
        rd_reg(`RSFR_A_STATUS, d); check(d, 16'h04C2);
        rd_reg(`RSFR_A_FLAGS, d); check(d, 16'h0002);
        wr_reg(`RSFR_A_FLAGS, 16'h0002);
        rd_reg(`RSFR_A_FLAGS, d); check(d, 16'h0000);
        // io undervoltage with default reaction: flag only
        @(posedge clk);
        uv <= 3'h2;
        repeat (100) @(posedge clk);
        rd_reg(`RSFR_A_FLAGS, d); check(d, 16'h0000);
        repeat (60) @(posedge clk);
        rd_reg(`RSFR_A_FLAGS, d); check(d, 16'h0010);
        check({15'h0, roe_n}, 16'h0001);
        @(posedge clk);
        uv <= 3'h0;
        repeat (10) @(posedge clk);
        rd_reg(`RSFR_A_STATUS, d); check(d & 16'h000F, 16'h0002);
        // standby resume, limit of two, one more fault
        @(posedge clk);
        stby <= 1'b1;
        @(posedge clk);
        stby <= 1'b0;
        rd_reg(`RSFR_A_STATUS, d); check(d & 16'h000F, 16'h0001);
        wr_reg(`RSFR_A_REACT, 16'h0666);
        ov <= 3'h2;
        wait_rst(n);
        @(posedge clk);
        ov <= 3'h0;
        repeat (12) @(posedge clk);
        check({15'h0, deep}, 16'h0001);
        check({14'h0, roe_n, poe_n}, 16'h0000);
        rd_reg(`RSFR_A_STATUS, d); check(d & 16'h001F, 16'h0012);
        // aux rail fed by the pre-regulator, source set over the register port
        wr_reg(`RSFR_A_AUXSRC, {13'h0000, `RSFR_SRC_PRE});
        rd_reg(`RSFR_A_AUXSRC, d); check(d, 16'h0001);
        @(posedge clk);
        ov <= 3'h4;
        repeat (640) @(posedge clk);
        check({12'h000, off}, 16'h0002);
        check({14'h0, rdrv, pdrv}, 16'h0000);
        @(posedge clk);
        ov <= 3'h0;
        repeat (12) @(posedge clk);
        check({12'h000, off}, 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
